// file: hdl/sfc_defines.vh
// Constants for the serial flash command interpreter.
// Assumes inclusion by the design files only; definitions only.
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH
`define SFC_OP_WREN 8'h06
`define SFC_OP_VWREN 8'h50
`define SFC_OP_WRDI 8'h04
`define SFC_OP_RDSR1 8'h05
`define SFC_OP_RDSR2 8'h35
`define SFC_OP_WRSR 8'h01
`define SFC_OP_WRSR2 8'h31
`define SFC_OP_READ 8'h03
`define SFC_OP_PROG 8'h02
`define SFC_OP_QIOR 8'hEB
`define SFC_OP_QPIEN 8'h38
`define SFC_SR1_WMASK 8'hFC
`define SFC_SR2_WMASK 8'h43
`define SFC_SR1_RST 8'h00
`define SFC_SR2_RST 8'h00
`define SFC_BIT_BUSY 0
`define SFC_BIT_WEL 1
`define SFC_BIT_QE 1
`define SFC_ADDR_BITS 24
`define SFC_ADDR_BYTES 5'd24
`define SFC_PAGE_BITS 8
`define SFC_TW_NS 5000
`define SFC_CLK_NS 8
`define SFC_QIO_ADDR_CLKS 5'd8
`define SFC_QIO_DUMMY_CLKS 5'd4
`define SFC_CNT_W 20
`endif

// file: hdl/sfc_edge_sync.v
// Two-flop synchroniser with edge detection for a pin input.
// Assumes the pin is asynchronous to core_clk.
module sfc_edge_sync #(
  parameter IDLE = 1'b0
) (
  input wire core_clk,
  input wire reset_n,
  input wire pin,
  output reg level,
  output reg rise,
  output reg fall
);
  reg meta;
  reg sync;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Reset to the pin's idle level so no false edge follows reset
      meta <= IDLE;
      sync <= IDLE;
      level <= IDLE;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      level <= sync;
      rise <= sync & ~level;
      fall <= ~sync & level;
    end
  end
endmodule // sfc_edge_sync

// file: hdl/sfc_flash_cmd.v
// Serial flash command interpreter, device side, oversampling the link clock.
// Assumes serial clock well below core_clk/4; memory array held in a small array.
//
// Functional notes
// - All bytes move most significant bit first
// - Status read repeats byte while selected
// - Program data beyond 256 wraps in page
// - Quad address: one nibble per clock
// - Quad data high nibble first, lane3 top
// - Quad read: four dummy clocks before data
// - Write enable sets write latch flag
// - Volatile enable allows status write without latch
// - Write disable clears write latch flag
// - Latch cleared at reset and op end
// - Status reads always accepted, falling-edge output
// - Status write changes only writable bits
// - Status write needs latch set or volatile enable
// - Status write ends at bit 8 or 16
// - Eight-bit status write clears second byte bits
// - Self-timed busy cycle, latch cleared at start
// - Second byte write updates only its bits
// - Normal read: address then incrementing data
// - Normal read ignored while busy
// - Quad mode command needs quad enable bit
`include "sfc_defines.vh"
module sfc_flash_cmd #(
  parameter TW_CYCLES = (`SFC_TW_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS
) (
  input wire core_clk,
  input wire reset_n,
  input wire chip_sel_n,
  input wire serial_clk,
  input wire lane0_in,
  input wire lane1_in,
  input wire lane2_in,
  input wire lane3_in,
  output reg lane0_out,
  output reg lane1_out,
  output reg lane2_out,
  output reg lane3_out,
  output reg lane0_oe_n,
  output reg lane1_oe_n,
  output reg lane2_oe_n,
  output reg lane3_oe_n,
  output reg busy,
  output reg write_latch_flag,
  output reg quad_command_mode,
  output reg [7:0] status_byte1,
  output reg [7:0] status_byte2,
  output reg [2:0] wrap_setting
);
  localparam ST_OPCODE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_DATA_IN = 3'd2;
  localparam ST_DATA_OUT = 3'd3;
  localparam ST_QADDR = 3'd4;
  localparam ST_QDUMMY = 3'd5;
  localparam ST_QOUT = 3'd6;
  localparam ST_IGNORE = 3'd7;

  wire cs_n_lvl;
  wire cs_rise;
  wire cs_fall;
  wire sck_rise;
  wire sck_fall;
  wire [3:0] lanes;
  reg [3:0] lane_m;
  reg [3:0] lane_s;

  sfc_edge_sync #(.IDLE(1'b1)) u_cs (
    .core_clk(core_clk), .reset_n(reset_n), .pin(chip_sel_n),
    .level(cs_n_lvl), .rise(cs_rise), .fall(cs_fall)
  );
  sfc_edge_sync u_sck (
    .core_clk(core_clk), .reset_n(reset_n), .pin(serial_clk),
    .level(), .rise(sck_rise), .fall(sck_fall)
  );

  // Data lanes take one more stage so they line up with the clock edge detect
  reg [3:0] lane_d;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lane_m <= 4'h0;
      lane_s <= 4'h0;
      lane_d <= 4'h0;
    end else begin
      lane_m <= {lane3_in, lane2_in, lane1_in, lane0_in};
      lane_s <= lane_m;
      lane_d <= lane_s;
    end
  end
  assign lanes = lane_d;

  // Small backing store; the upper address bits alias onto it
  reg [7:0] mem [0:255];
  reg [7:0] page_buf [0:255];

  reg [2:0] state;
  reg [7:0] opcode;
  reg [7:0] shreg;
  reg [4:0] bitcnt;
  reg [4:0] clkcnt;
  reg [23:0] addr;
  reg [7:0] out_byte;
  reg [2:0] out_bit;
  reg out_nib;
  reg [4:0] wr_bits;
  reg [15:0] wr_data;
  reg vol_enable;
  reg vol_pending;
  reg [7:0] prog_cnt;
  reg [8:0] prog_total;
  reg [23:0] prog_base;
  reg [7:0] prog_start;
  reg prog_active;
  reg [`SFC_CNT_W-1:0] busy_cnt;
  reg [7:0] pending_sr1;
  reg [7:0] pending_sr2;
  reg sr_pending;
  reg [8:0] copy_idx;

  wire [7:0] next_byte = {shreg[6:0], lanes[0]};

  function [7:0] status_sel;
    input [7:0] op;
    input [7:0] s1;
    input [7:0] s2;
    begin
      status_sel = (op == `SFC_OP_RDSR2) ? s2 : s1;
    end
  endfunction

  always @(posedge core_clk) begin
    if (state == ST_DATA_IN && sck_rise && bitcnt == 5'd7 && !cs_n_lvl)
      page_buf[prog_cnt] <= next_byte;
  end
  always @(posedge core_clk) begin
    // Copy from the start offset so bytes land where they were addressed
    if (prog_active && busy && !copy_idx[8] && (prog_total[8] || copy_idx < prog_total))
      mem[prog_start + copy_idx[7:0]] <= page_buf[prog_start + copy_idx[7:0]];
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_OPCODE;
      opcode <= 8'h00;
      shreg <= 8'h00;
      bitcnt <= 5'd0;
      clkcnt <= 5'd0;
      addr <= 24'h000000;
      out_byte <= 8'h00;
      out_bit <= 3'd7;
      out_nib <= 1'b0;
      wr_bits <= 5'd0;
      wr_data <= 16'h0000;
      vol_enable <= 1'b0;
      vol_pending <= 1'b0;
      prog_cnt <= 8'h00;
      prog_total <= 9'd0;
      prog_base <= 24'h000000;
      prog_start <= 8'h00;
      prog_active <= 1'b0;
      busy_cnt <= {`SFC_CNT_W{1'b0}};
      pending_sr1 <= 8'h00;
      pending_sr2 <= 8'h00;
      sr_pending <= 1'b0;
      copy_idx <= 9'd0;
      busy <= 1'b0;
      write_latch_flag <= 1'b0;
      quad_command_mode <= 1'b0;
      status_byte1 <= `SFC_SR1_RST;
      status_byte2 <= `SFC_SR2_RST;
      wrap_setting <= 3'd0;
      {lane3_out, lane2_out, lane1_out, lane0_out} <= 4'h0;
      {lane3_oe_n, lane2_oe_n, lane1_oe_n, lane0_oe_n} <= 4'hF;
    end else begin
      // Self-timed cycle
      if (busy) begin
        if (copy_idx != 9'd256)
          copy_idx <= copy_idx + 9'd1;
        if (busy_cnt == TW_CYCLES[`SFC_CNT_W-1:0] - 1'b1) begin
          busy <= 1'b0;
          prog_active <= 1'b0;
          if (sr_pending) begin
            status_byte1 <= (status_byte1 & ~`SFC_SR1_WMASK) | (pending_sr1 & `SFC_SR1_WMASK);
            status_byte2 <= (status_byte2 & ~`SFC_SR2_WMASK) | (pending_sr2 & `SFC_SR2_WMASK);
            sr_pending <= 1'b0;
          end
        end else begin
          busy_cnt <= busy_cnt + 1'b1;
        end
      end
      if (cs_rise) begin
        {lane3_oe_n, lane2_oe_n, lane1_oe_n, lane0_oe_n} <= 4'hF;
        state <= ST_OPCODE;
        bitcnt <= 5'd0;
        // Status write commits only on an exact byte boundary
        if (state == ST_DATA_IN && (opcode == `SFC_OP_WRSR || opcode == `SFC_OP_WRSR2)
            && bitcnt == 5'd0 && (write_latch_flag || vol_pending) && !busy) begin
          if (opcode == `SFC_OP_WRSR && wr_bits == 5'd8) begin
            pending_sr1 <= wr_data[7:0];
            pending_sr2 <= 8'h00;
          end else if (opcode == `SFC_OP_WRSR && wr_bits == 5'd16) begin
            pending_sr1 <= wr_data[15:8];
            pending_sr2 <= wr_data[7:0];
          end else if (opcode == `SFC_OP_WRSR2 && wr_bits == 5'd8) begin
            pending_sr1 <= status_byte1;
            pending_sr2 <= wr_data[7:0];
          end
          if ((opcode == `SFC_OP_WRSR && (wr_bits == 5'd8 || wr_bits == 5'd16)) ||
              (opcode == `SFC_OP_WRSR2 && wr_bits == 5'd8)) begin
            sr_pending <= 1'b1;
            // Volatile path gets a one-cycle busy only
            busy_cnt <= {`SFC_CNT_W{1'b0}};
            if (vol_pending)
              busy_cnt <= TW_CYCLES[`SFC_CNT_W-1:0] - 1'b1;
            busy <= 1'b1;
            write_latch_flag <= 1'b0;
          end
        end
        if (state == ST_DATA_IN && opcode == `SFC_OP_PROG && write_latch_flag && !busy
            && prog_total != 9'd0) begin
          prog_active <= 1'b1;
          busy <= 1'b1;
          busy_cnt <= {`SFC_CNT_W{1'b0}};
          copy_idx <= 9'd0;
          write_latch_flag <= 1'b0;
        end
        if (opcode != `SFC_OP_VWREN)
          vol_pending <= 1'b0;
      end else if (cs_fall) begin
        state <= ST_OPCODE;
        bitcnt <= 5'd0;
        shreg <= 8'h00;
        wr_bits <= 5'd0;
        prog_cnt <= 8'h00;
        prog_total <= 9'd0;
      end else if (!cs_n_lvl && sck_rise) begin
        shreg <= next_byte;
        case (state)
          ST_OPCODE: begin
            bitcnt <= bitcnt + 5'd1;
            if (bitcnt == 5'd7) begin
              bitcnt <= 5'd0;
              opcode <= next_byte;
              state <= ST_IGNORE;
              case (next_byte)
                `SFC_OP_WREN: if (!busy) write_latch_flag <= 1'b1;
                `SFC_OP_WRDI: if (!busy) write_latch_flag <= 1'b0;
                `SFC_OP_VWREN: vol_pending <= 1'b1;
                `SFC_OP_RDSR1, `SFC_OP_RDSR2: begin
                  out_byte <= status_sel(next_byte, {status_byte1[7:2], write_latch_flag,
                    busy}, status_byte2);
                  out_bit <= 3'd7;
                  state <= ST_DATA_OUT;
                end
                `SFC_OP_READ: if (!busy) state <= ST_ADDR;
                `SFC_OP_PROG: if (!busy) state <= ST_ADDR;
                `SFC_OP_WRSR, `SFC_OP_WRSR2: if (!busy) state <= ST_DATA_IN;
                `SFC_OP_QIOR: if (!busy && status_byte2[`SFC_BIT_QE]) begin
                  state <= ST_QADDR;
                  clkcnt <= 5'd0;
                end
                `SFC_OP_QPIEN: if (status_byte2[`SFC_BIT_QE])
                  quad_command_mode <= 1'b1;
                default: state <= ST_IGNORE;
              endcase
            end
          end
          ST_ADDR: begin
            addr <= {addr[22:0], lanes[0]};
            bitcnt <= bitcnt + 5'd1;
            if (bitcnt == `SFC_ADDR_BYTES - 5'd1) begin
              bitcnt <= 5'd0;
              if (opcode == `SFC_OP_READ) begin
                out_byte <= mem[{addr[6:0], lanes[0]}];
                out_bit <= 3'd7;
                addr <= {addr[22:0], lanes[0]} + 24'h000001;
                state <= ST_DATA_OUT;
              end else begin
                prog_base <= {addr[22:8], 8'h00};
                prog_cnt <= {addr[6:0], lanes[0]};
                prog_start <= {addr[6:0], lanes[0]};
                state <= ST_DATA_IN;
              end
            end
          end
          ST_DATA_IN: begin
            bitcnt <= (bitcnt == 5'd7) ? 5'd0 : bitcnt + 5'd1;
            if (opcode != `SFC_OP_PROG) begin
              wr_data <= {wr_data[14:0], lanes[0]};
              if (wr_bits != 5'd31)
                wr_bits <= wr_bits + 5'd1;
            end else if (bitcnt == 5'd7) begin
              prog_cnt <= prog_cnt + 8'h01;
              if (!prog_total[8])
                prog_total <= prog_total + 9'd1;
            end
          end
          ST_QADDR: begin
            addr <= {addr[19:0], lanes};
            clkcnt <= clkcnt + 5'd1;
            if (clkcnt == `SFC_QIO_ADDR_CLKS - 5'd1) begin
              clkcnt <= 5'd0;
              state <= ST_QDUMMY;
            end
          end
          ST_QDUMMY: begin
            clkcnt <= clkcnt + 5'd1;
            if (clkcnt == `SFC_QIO_DUMMY_CLKS - 5'd1) begin
              out_byte <= mem[addr[15:8]];
              addr <= {addr[23:8], 8'h00} + 24'h000100;
              out_nib <= 1'b0;
              state <= ST_QOUT;
            end
          end
          default: ;
        endcase
      end else if (!cs_n_lvl && sck_fall) begin
        if (state == ST_DATA_OUT) begin
          lane1_oe_n <= 1'b0;
          lane1_out <= out_byte[out_bit];
          out_bit <= out_bit - 3'd1;
          if (out_bit == 3'd0) begin
            if (opcode == `SFC_OP_READ) begin
              out_byte <= mem[addr[7:0]];
              addr <= addr + 24'h000001;
            end else begin
              out_byte <= status_sel(opcode, {status_byte1[7:2], write_latch_flag,
                busy}, status_byte2);
            end
          end
        end else if (state == ST_QOUT) begin
          {lane3_oe_n, lane2_oe_n, lane1_oe_n, lane0_oe_n} <= 4'h0;
          {lane3_out, lane2_out, lane1_out, lane0_out} <=
            out_nib ? out_byte[3:0] : out_byte[7:4];
          out_nib <= ~out_nib;
          if (out_nib) begin
            out_byte <= mem[addr[15:8]];
            addr <= addr + 24'h000100;
          end
        end
      end
    end
  end
endmodule // sfc_flash_cmd

// file: verification/sfc_flash_cmd_assertions.sv
// Port checker for the flash command interpreter, attached by bind.
// Assumes one core_clk domain with the async active-low reset.
module sfc_chk #(
  parameter TW_CYCLES = 625
) (
  input wire core_clk,
  input wire reset_n,
  input wire chip_sel_n,
  input wire serial_clk,
  input wire lane1_out,
  input wire lane0_oe_n,
  input wire lane1_oe_n,
  input wire lane2_oe_n,
  input wire lane3_oe_n,
  input wire busy,
  input wire write_latch_flag,
  input wire quad_command_mode,
  input wire [7:0] status_byte2
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [15:0] bcnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      bcnt <= 16'h0000;
    else
      bcnt <= busy ? bcnt + 16'h0001 : 16'h0000;
  end
  a_lanes_released: assert property (
    chip_sel_n [*6] |-> (lane0_oe_n && lane1_oe_n && lane2_oe_n && lane3_oe_n))
    else $error("lanes driven while deselected");
  a_latch_on_busy: assert property ($rose(busy) |-> ##[0:2] !write_latch_flag)
    else $error("latch not cleared at busy start");
  // Volatile writes give a very short busy, hence the second branch
  a_busy_length: assert property (
    $fell(busy) |-> (bcnt <= TW_CYCLES + 1) && (bcnt + 1 >= TW_CYCLES || bcnt <= 2))
    else $error("busy time wrong");
  a_done_latch: assert property ($fell(busy) |-> !write_latch_flag)
    else $error("latch set after operation end");
  a_ro_bits: assert property ((status_byte2 & 8'hBC) == 8'h00)
    else $error("read-only status bit changed");
  a_quad_needs_qe: assert property ($rose(quad_command_mode) |-> status_byte2[1])
    else $error("quad mode without quad enable");
  a_busy_after_cs: assert property ($rose(busy) |-> chip_sel_n)
    else $error("busy began inside a frame");
  a_out_on_fall: assert property (
    (!chip_sel_n && !lane1_oe_n && $stable(lane1_oe_n) && $changed(lane1_out)) |-> !serial_clk)
    else $error("output moved while clock high");
endmodule // sfc_chk

bind sfc_flash_cmd sfc_chk #(.TW_CYCLES(TW_CYCLES)) sfc_chk_i (
  .core_clk(core_clk), .reset_n(reset_n), .chip_sel_n(chip_sel_n),
  .serial_clk(serial_clk), .lane1_out(lane1_out), .lane0_oe_n(lane0_oe_n),
  .lane1_oe_n(lane1_oe_n), .lane2_oe_n(lane2_oe_n), .lane3_oe_n(lane3_oe_n),
  .busy(busy), .write_latch_flag(write_latch_flag),
  .quad_command_mode(quad_command_mode), .status_byte2(status_byte2));

// file: verification/sfc_host_model.sv
// Host serial controller model driving chip select, clock and lanes.
// Assumes clock idles low and stands still between frames.
module sfc_host_model (
  input wire core_clk,
  input wire lane1_out,
  output reg chip_sel_n,
  output reg serial_clk,
  output reg lane0_in,
  output reg lane1_in,
  output reg lane2_in,
  output reg lane3_in
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [7:0] rx;
  event got;
  initial begin
    chip_sel_n = 1'b1;
    serial_clk = 1'b0;
    lane0_in = 1'b0;
    lane1_in = 1'b0;
    lane2_in = 1'b0;
    lane3_in = 1'b1;
    rx = 8'h00;
  end
  // Unused lanes toggle so a stale level never passes for data
  always @(posedge core_clk) begin
    lane1_in <= ~lane1_in;
    lane2_in <= ~lane2_in;
    lane3_in <= ~lane3_in;
  end
  task start;
    @(posedge core_clk);
    chip_sel_n <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
  task stop;
    chip_sel_n <= 1'b1;
    lane0_in <= ~lane0_in;
    repeat (12) @(posedge core_clk);
  endtask
  task bit_x(input b, output r);
    lane0_in <= b;
    repeat (10) @(posedge core_clk);
    serial_clk <= 1'b1;
    r = lane1_out;
    repeat (10) @(posedge core_clk);
    serial_clk <= 1'b0;
  endtask
  task byte_x(input [7:0] b, output [7:0] r);
    integer k;
    for (k = 7; k >= 0; k = k - 1) bit_x(b[k], r[k]);
  endtask
  task rd;
    byte_x(~rx, rx);
    -> got;
  endtask
endmodule // sfc_host_model

// file: verification/tb.sv
// Self-checking bench: host model on the pins, checker bound inside.
// Assumes busy time set to 2000 cycles through TW_CYCLES.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam TW = 2000;
  reg core_clk = 1'b0;
  reg reset_n = 1'b0;
  wire chip_sel_n, serial_clk, lane0_in, lane1_in, lane1_host, lane2_in, lane3_in;
  wire lane1_out, lane0_oe_n, lane1_oe_n, lane2_oe_n, lane3_oe_n;
  wire busy, write_latch_flag, quad_command_mode;
  wire [7:0] status_byte1, status_byte2;
  reg [7:0] exp_q[$];
  reg [7:0] r, v1, v2;
  reg [7:0] d[0:2];
  integer error_cnt = 0;
  integer comparisons = 0;
  integer i;
  assign lane1_in = lane1_oe_n ? lane1_host : lane1_out;
  sfc_flash_cmd #(.TW_CYCLES(TW)) sfc_flash_cmd_i (
    .core_clk(core_clk), .reset_n(reset_n), .chip_sel_n(chip_sel_n),
    .serial_clk(serial_clk), .lane0_in(lane0_in), .lane1_in(lane1_in),
    .lane2_in(lane2_in), .lane3_in(lane3_in), .lane0_out(), .lane1_out(lane1_out),
    .lane2_out(), .lane3_out(), .lane0_oe_n(lane0_oe_n), .lane1_oe_n(lane1_oe_n),
    .lane2_oe_n(lane2_oe_n), .lane3_oe_n(lane3_oe_n), .busy(busy),
    .write_latch_flag(write_latch_flag), .quad_command_mode(quad_command_mode),
    .status_byte1(status_byte1), .status_byte2(status_byte2), .wrap_setting());
  sfc_host_model sfc_host_model_i (
    .core_clk(core_clk), .lane1_out(lane1_out), .chip_sel_n(chip_sel_n),
    .serial_clk(serial_clk), .lane0_in(lane0_in), .lane1_in(lane1_host),
    .lane2_in(lane2_in), .lane3_in(lane3_in));
  task chk(input [7:0] got, input [7:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task sb(input [7:0] b);
    sfc_host_model_i.byte_x(b, r);
  endtask
  task s4(input [31:0] w);
    integer k;
    for (k = 3; k >= 0; k = k - 1) sb(w[k*8 +: 8]);
  endtask
  task op1(input [7:0] op);
    sfc_host_model_i.start;
    sb(op);
    sfc_host_model_i.stop;
  endtask
  task wsr(input [7:0] op, input [7:0] a, input [7:0] b, input two);
    sfc_host_model_i.start;
    sb(op);
    sb(a);
    if (two) sb(b);
    sfc_host_model_i.stop;
  endtask
  task rsr(input [7:0] op, input [7:0] e);
    sfc_host_model_i.start;
    sb(op);
    exp_q.push_back(e);
    exp_q.push_back(e);
    sfc_host_model_i.rd;
    sfc_host_model_i.rd;
    sfc_host_model_i.stop;
  endtask
  task idle;
    for (i = 0; i < 3000 && busy !== 1'b0; i = i + 1) @(posedge core_clk);
    #1;
    // A busy that never ends counts as a mismatch
    if (busy !== 1'b0) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t ns: got %h expected %h", $time, busy, 1'b0);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  always @(sfc_host_model_i.got) chk(sfc_host_model_i.rx, exp_q.pop_front());
  initial begin
    // About two and a half times the expected run, well under the cycle budget
    #400000;
    error_cnt = error_cnt + 1;
    give_verdict;
  end
  initial begin
    v1 = $urandom(32'hd9bb5385);
    v1 = ($urandom & 8'hFE) | 8'h02;
    v2 = ($urandom & 8'hFE) | 8'h02;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({busy, write_latch_flag, quad_command_mode}, 8'h00);
    chk({lane0_oe_n, lane1_oe_n, lane2_oe_n, lane3_oe_n}, 8'h0F);
    $display("test 1 done");
    op1(8'h06);
    chk(write_latch_flag, 1'b1);
    op1(8'h04);
    chk(write_latch_flag, 1'b0);
    wsr(8'h01, v1, v2, 1'b1);
    chk(busy, 1'b0);
    op1(8'h06);
    sfc_host_model_i.start;
    sb(8'h01);
    sb(v1);
    for (i = 0; i < 4; i = i + 1) sfc_host_model_i.bit_x(v2[i], r[0]);
    sfc_host_model_i.stop;
    chk(busy, 1'b0);
    chk(status_byte1 & 8'hFC, 8'h00);
    $display("test 2 done");
    wsr(8'h01, v1, v2, 1'b1);
    chk({busy, write_latch_flag}, 8'h02);
    sfc_host_model_i.start;
    s4({8'h03, 24'h000010});
    sb(8'h00);
    chk({busy, lane1_oe_n}, 8'h03);
    sfc_host_model_i.stop;
    idle;
    chk(write_latch_flag, 1'b0);
    rsr(8'h05, v1 & 8'hFC);
    rsr(8'h35, v2 & 8'h43);
    $display("test 3 done");
    op1(8'h06);
    wsr(8'h01, v2, v1, 1'b0);
    idle;
    chk(status_byte2, 8'h00);
    chk(status_byte1 & 8'hFC, v2 & 8'hFC);
    op1(8'h06);
    wsr(8'h31, v1, v2, 1'b0);
    idle;
    chk(status_byte1 & 8'hFC, v2 & 8'hFC);
    rsr(8'h35, v1 & 8'h43);
    $display("test 4 done");
    op1(8'h50);
    wsr(8'h01, v1, v2, 1'b0);
    idle;
    chk(status_byte1 & 8'hFC, v1 & 8'hFC);
    chk(write_latch_flag, 1'b0);
    op1(8'h50);
    wsr(8'h01, 8'h00, v2, 1'b0);
    idle;
    $display("test 5 done");
    for (i = 0; i < 3; i = i + 1) d[i] = $urandom;
    op1(8'h06);
    sfc_host_model_i.start;
    s4({8'h02, 24'h0000FE});
    for (i = 0; i < 3; i = i + 1) sb(d[i]);
    sfc_host_model_i.stop;
    idle;
    chk(write_latch_flag, 1'b0);
    sfc_host_model_i.start;
    s4({8'h03, 24'h0000FE});
    for (i = 0; i < 3; i = i + 1) exp_q.push_back(d[i]);
    repeat (3) sfc_host_model_i.rd;
    sfc_host_model_i.stop;
    $display("test 6 done");
    op1(8'h38);
    chk(quad_command_mode, 1'b0);
    op1(8'h06);
    wsr(8'h31, 8'h02, 8'h00, 1'b0);
    idle;
    op1(8'h38);
    chk(quad_command_mode, 1'b1);
    $display("test 7 done");
    give_verdict;
  end
endmodule // tb
